// *** verilog/ssr_defines.svh ***
// bit positions, reset values and error number ranges of the status logic
// assumes inclusion by the design file only
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
`define SSR_STB_QUES      3
`define SSR_STB_ERR       2
`define SSR_STB_MAV       4
`define SSR_STB_ESB       5
`define SSR_STB_MSS       6
`define SSR_STB_OPER      7
`define SSR_ESR_OPC       0
`define SSR_ESR_QYE       2
`define SSR_ESR_DDE       3
`define SSR_ESR_EXE       4
`define SSR_ESR_CME       5
`define SSR_ESR_URQ       6
`define SSR_ESR_PON       7
`define SSR_ESR_USED      8'hFD
`define SSR_STB_USED      8'hFC
`define SSR_SRE_IGN       8'h40
`define SSR_MASK_RST      8'h00
`define SSR_ESR_RST       8'h80
`define SSR_ERR_DEV_LO    (-399)
`define SSR_ERR_DEV_HI    (-300)
`define SSR_ERR_EXE_LO    (-299)
`define SSR_ERR_EXE_HI    (-200)
`define SSR_ERR_CMD_LO    (-199)
`define SSR_ERR_CMD_HI    (-100)
`endif

// *** verilog/ssr_pkg.sv ***
// types shared by the status byte and event status logic
// assumes the defines header is on the include path
package ssr_pkg;
  typedef enum logic [2:0] {
    SSR_EV_NONE  = 3'b000,
    SSR_EV_QUERY = 3'b001,
    SSR_EV_DEV   = 3'b010,
    SSR_EV_EXEC  = 3'b011,
    SSR_EV_CMD   = 3'b100
  } ssr_err_kind_t;

  typedef struct packed {
    logic        valid;
    ssr_err_kind_t kind;
    logic [15:0] code;
  } ssr_err_t;

  typedef struct packed {
    logic       wr_ese;
    logic       wr_sre;
    logic [7:0] data;
  } ssr_mask_wr_t;

  typedef enum logic [1:0] {
    SSR_OPC_IDLE = 2'b00,
    SSR_OPC_WAIT = 2'b01
  } ssr_opc_state_t;
endpackage

// *** verilog/ssr_status.sv ***
// status byte, event status register and service request generation
// assumes the command parser drives one-cycle pulses synchronous to clk
`timescale 1ns/1ns
`include "ssr_defines.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// - new error queue entry sets status byte bit 2.
// - request mask bit 2 set makes every new error entry request service.
// - bit 3 set when questionable summary (event and enable) is set.
// - bit 4 set while a response message waits in output queue.
// - bit 5 set when any enabled event status bit is set.
// - bit 6 set when another enabled status byte bit is set.
// - bit 7 set when operation summary (event and enable) is set.
// - event summary bit set when an enabled event bit rises 0 to 1.
// - event enable mask written by set command, read back by query.
// - event bit 0 set after op-complete once prior commands are done.
// - event bit 2 set on read without query or unfetched response.
// - device error sets bit 3 and queues code -300..-399 or positive.
// - execution error sets bit 4 and queues code -200..-299.
// - command error sets bit 5 and queues code -100..-199.
// - event bit 6 set on switch from remote to local control.
// - event bit 7 set at power on.
// - reading the event status register returns it then clears it.
// - request mask bit 6 ignored; enabled bit rising requests service.
// - status byte answered to both query and serial poll.
module ssr_status
  import ssr_pkg::*;
#(
  parameter int ERRQ_DEPTH = 16                // error queue entries
) (
  input  wire logic         clk,                // 20 MHz system clock
  input  wire logic         srst,               // power-on clear
  input  wire ssr_mask_wr_t mask_wr,            // mask set commands
  input  wire logic         opc_cmd,            // op-complete received
  input  wire logic         cmds_idle,          // prior commands done
  input  wire ssr_err_t     err_in,             // error report pulse
  input  wire logic         err_pop,            // error queue read
  input  wire logic         to_local,           // remote to local switch
  input  wire logic         msg_waiting,        // output queue not empty
  input  wire logic         ques_summary,       // questionable sum bit
  input  wire logic         oper_summary,       // operation sum bit
  input  wire logic         esr_read,           // event status query
  input  wire logic         stb_read,           // status byte query
  input  wire logic         serial_poll,        // bus serial poll
  output logic [7:0]        event_enable_mask,  // readback of mask
  output logic [7:0]        request_enable_mask,// readback of mask
  output logic [7:0]        standard_event_status, // held event bits
  output logic [7:0]        esr_rdata,          // captured on read
  output logic [7:0]        summary_status_byte,// live status byte
  output logic [7:0]        stb_rdata,          // captured on read
  output logic              service_request,    // request line
  output logic [15:0]       err_head,           // oldest error code
  output logic              err_empty           // error queue empty
);

  localparam int AW = $clog2(ERRQ_DEPTH);

  logic [7:0]    ese_q, sre_q, esr_q, esr_d, esr_rd_q, stb_rd_q;
  logic [7:0]    stb_c, stb_prev_q;
  logic          srq_q;
  logic [15:0]   errq_mem [ERRQ_DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0]   cnt_q;
  ssr_opc_state_t opc_q;
  logic          opc_done;
  logic          err_push;
  logic          err_pop_ok;

  function automatic logic in_range(input logic [15:0] c,
                                    input int lo, input int hi);
    int v;
    v = int'($signed(c));
    return (v >= lo) && (v <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // masks, written and read back over the command port
  always_ff @(posedge clk) begin
    if (srst) begin
      ese_q <= `SSR_MASK_RST;
      sre_q <= `SSR_MASK_RST;
    end else begin
      if (mask_wr.wr_ese) ese_q <= mask_wr.data;
      if (mask_wr.wr_sre) sre_q <= mask_wr.data & ~`SSR_SRE_IGN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operation complete waits until earlier commands have drained
  always_ff @(posedge clk) begin
    if (srst) begin
      opc_q <= SSR_OPC_IDLE;
    end else begin
      case (opc_q)
        SSR_OPC_IDLE: if (opc_cmd && !cmds_idle) opc_q <= SSR_OPC_WAIT;
        SSR_OPC_WAIT: if (cmds_idle) opc_q <= SSR_OPC_IDLE;
        default:      opc_q <= SSR_OPC_IDLE;
      endcase
    end
  end
  assign opc_done = (opc_q == SSR_OPC_IDLE && opc_cmd && cmds_idle) ||
                    (opc_q == SSR_OPC_WAIT && cmds_idle);

  ////////////////////////////////////////////////////////////////////////////
  // event status: sets win over the clear-on-read
  always_comb begin
    esr_d = esr_read ? 8'h00 : esr_q;
    if (opc_done) esr_d[`SSR_ESR_OPC] = 1'b1;
    if (err_in.valid && err_in.kind == SSR_EV_QUERY)
      esr_d[`SSR_ESR_QYE] = 1'b1;
    if (err_in.valid && err_in.kind == SSR_EV_DEV)
      esr_d[`SSR_ESR_DDE] = 1'b1;
    if (err_in.valid && err_in.kind == SSR_EV_EXEC)
      esr_d[`SSR_ESR_EXE] = 1'b1;
    if (err_in.valid && err_in.kind == SSR_EV_CMD)
      esr_d[`SSR_ESR_CME] = 1'b1;
    if (to_local) esr_d[`SSR_ESR_URQ] = 1'b1;
    esr_d = esr_d & `SSR_ESR_USED;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      esr_q    <= `SSR_ESR_RST;
      esr_rd_q <= 8'h00;
    end else begin
      esr_q <= esr_d;
      if (esr_read) esr_rd_q <= esr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error queue; a full queue drops the newest entry
  assign err_push = err_in.valid && err_in.kind != SSR_EV_NONE &&
                    cnt_q != (AW+1)'(ERRQ_DEPTH);

  always_ff @(posedge clk) begin
    if (err_push) errq_mem[wp_q] <= err_in.code;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (err_push) wp_q <= wp_q + 1'b1;
      if (err_pop_ok) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(err_push) - (AW+1)'(err_pop_ok);
    end
  end
  assign err_head  = (cnt_q != '0) ? errq_mem[rp_q] : 16'h0000;
  assign err_empty = (cnt_q == '0);
  assign err_pop_ok = err_pop && cnt_q != '0;

  ////////////////////////////////////////////////////////////////////////////
  // status byte and service request
  always_comb begin
    stb_c = 8'h00;
    stb_c[`SSR_STB_ERR]  = !err_empty;
    stb_c[`SSR_STB_QUES] = ques_summary;
    stb_c[`SSR_STB_MAV]  = msg_waiting;
    stb_c[`SSR_STB_ESB]  = |(esr_q & ese_q);
    stb_c[`SSR_STB_OPER] = oper_summary;
    stb_c[`SSR_STB_MSS]  = |(stb_c & sre_q & ~`SSR_SRE_IGN);
    stb_c = stb_c & `SSR_STB_USED;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stb_prev_q <= 8'h00;
      srq_q      <= 1'b0;
      stb_rd_q   <= 8'h00;
    end else begin
      stb_prev_q <= stb_c;
      // a new error entry re-requests even when bit 2 already stood
      if (|(stb_c & ~stb_prev_q & sre_q & ~`SSR_SRE_IGN) ||
          (err_push && sre_q[`SSR_STB_ERR]))
        srq_q <= 1'b1;
      else if (!stb_c[`SSR_STB_MSS])
        srq_q <= 1'b0;
      if (stb_read || serial_poll) stb_rd_q <= stb_c;
    end
  end

  assign event_enable_mask     = ese_q;
  assign request_enable_mask   = sre_q;
  assign standard_event_status = esr_q;
  assign esr_rdata             = esr_rd_q;
  assign summary_status_byte   = stb_c;
  assign stb_rdata             = stb_rd_q;
  assign service_request       = srq_q;

  ////////////////////////////////////////////////////////////////////////////
  AST_ERR_BIT: assert property (@(posedge clk) disable iff (srst)
    err_push |=> summary_status_byte[2])
    else $error("error entry did not set status bit 2");
  AST_ERR_SRQ: assert property (@(posedge clk) disable iff (srst)
    err_push && sre_q[2] && !mask_wr.wr_sre |=> service_request)
    else $error("error entry with mask bit 2 gave no request");
  AST_QUES: assert property (@(posedge clk) disable iff (srst)
    summary_status_byte[3] == ques_summary)
    else $error("questionable bit wrong");
  AST_MAV: assert property (@(posedge clk) disable iff (srst)
    summary_status_byte[4] == msg_waiting)
    else $error("message bit wrong");
  AST_ESB: assert property (@(posedge clk) disable iff (srst)
    summary_status_byte[5] == |(standard_event_status & event_enable_mask))
    else $error("event summary bit wrong");
  AST_MSS: assert property (@(posedge clk) disable iff (srst)
    summary_status_byte[6] == |(summary_status_byte & sre_q & 8'hBF))
    else $error("master summary bit wrong");
  AST_OPER: assert property (@(posedge clk) disable iff (srst)
    summary_status_byte[7] == oper_summary)
    else $error("operation bit wrong");
  AST_ESE_WR: assert property (@(posedge clk) disable iff (srst)
    mask_wr.wr_ese |=> event_enable_mask == $past(mask_wr.data))
    else $error("event mask not written");
  AST_OPC: assert property (@(posedge clk) disable iff (srst)
    opc_cmd && cmds_idle |=> standard_event_status[0])
    else $error("op complete not recorded");
  AST_CME: assert property (@(posedge clk) disable iff (srst)
    err_in.valid && err_in.kind == SSR_EV_CMD |=> standard_event_status[5])
    else $error("command error not recorded");
  AST_URQ: assert property (@(posedge clk) disable iff (srst)
    to_local |=> standard_event_status[6])
    else $error("user request not recorded");
  AST_RDCLR: assert property (@(posedge clk) disable iff (srst)
    esr_read && !opc_cmd && !err_in.valid && !to_local && opc_q ==
    SSR_OPC_IDLE |=> standard_event_status == 8'h00 &&
    esr_rdata == $past(standard_event_status))
    else $error("event read did not return and clear");
  AST_SRE6: assert property (@(posedge clk) disable iff (srst)
    !request_enable_mask[6])
    else $error("request mask bit 6 kept");
  AST_ZERO: assert property (@(posedge clk) disable iff (srst)
    summary_status_byte[1:0] == 2'b00 && !standard_event_status[1])
    else $error("unused bit set");
  AST_EMPTY: assert property (@(posedge clk) disable iff (srst)
    err_empty |-> !summary_status_byte[2])
    else $error("error bit set with empty queue");

  ////////////////////////////////////////////////////////////////////////////
  // event capture, request timing and values that stand until their event
  AST_QYE: assert property (@(posedge clk) disable iff (srst)
    err_in.valid && err_in.kind == SSR_EV_QUERY |=> standard_event_status[2])
    else $error("query error not recorded");
  AST_DDE: assert property (@(posedge clk) disable iff (srst)
    err_in.valid && err_in.kind == SSR_EV_DEV |=> standard_event_status[3])
    else $error("device error not recorded");
  AST_EXE: assert property (@(posedge clk) disable iff (srst)
    err_in.valid && err_in.kind == SSR_EV_EXEC |=> standard_event_status[4])
    else $error("execution error not recorded");
  AST_ESB_RISE: assert property (@(posedge clk) disable iff (srst)
    err_in.valid && err_in.kind == SSR_EV_CMD && event_enable_mask[5] &&
    !mask_wr.wr_ese |=> summary_status_byte[5])
    else $error("enabled event rise gave no event summary");
  AST_PON: assert property (@(posedge clk) disable iff (srst)
    $fell(srst) |-> standard_event_status[7])
    else $error("power on bit missing after reset");
  AST_STB_CAP: assert property (@(posedge clk) disable iff (srst)
    stb_read || serial_poll |=> stb_rdata == $past(summary_status_byte))
    else $error("status byte read not captured");
  AST_SRQ_RISE: assert property (@(posedge clk) disable iff (srst)
    |(summary_status_byte & ~$past(summary_status_byte) & request_enable_mask)
    |=> service_request)
    else $error("enabled status bit rise gave no request");
  // the request line may outlive the master bit by one cycle, no longer
  AST_SRQ_DROP: assert property (@(posedge clk) disable iff (srst)
    !summary_status_byte[6] && !err_push |=> !service_request)
    else $error("request stood without master summary");
  AST_ERR_HEAD: assert property (@(posedge clk) disable iff (srst)
    err_push && err_empty |=> err_head == $past(err_in.code))
    else $error("queued error code not at head");
  AST_ERR_DRAIN: assert property (@(posedge clk) disable iff (srst)
    err_pop && cnt_q == (AW+1)'(1) && !err_push |=> err_empty)
    else $error("last error read did not empty queue");
  AST_POP_EMPTY: assert property (@(posedge clk) disable iff (srst)
    err_pop && err_empty && !err_push |=> err_empty)
    else $error("read of empty queue changed it");
  AST_ERR_SET: assert property (@(posedge clk) disable iff (srst)
    !err_empty |-> summary_status_byte[2])
    else $error("error bit clear with entries queued");
  AST_SRE_WR: assert property (@(posedge clk) disable iff (srst)
    mask_wr.wr_sre |=> request_enable_mask == ($past(mask_wr.data) & 8'hBF))
    else $error("request mask not written");
  AST_ESE_HOLD: assert property (@(posedge clk) disable iff (srst)
    !mask_wr.wr_ese |=> $stable(event_enable_mask))
    else $error("event mask changed without write");
  AST_OPC_WAIT: assert property (@(posedge clk) disable iff (srst)
    opc_cmd && !cmds_idle && opc_q == SSR_OPC_IDLE &&
    !standard_event_status[0] |=> !standard_event_status[0])
    else $error("op complete set while commands busy");
  AST_ESR_HOLD: assert property (@(posedge clk) disable iff (srst)
    !esr_read |=> (standard_event_status & $past(standard_event_status)) ==
    $past(standard_event_status))
    else $error("event bit lost without read");
  AST_ESR_RD_HOLD: assert property (@(posedge clk) disable iff (srst)
    !esr_read |=> $stable(esr_rdata))
    else $error("event read value changed without read");
  AST_STB_RD_HOLD: assert property (@(posedge clk) disable iff (srst)
    !stb_read && !serial_poll |=> $stable(stb_rdata))
    else $error("status byte capture changed without read");

endmodule // ssr_status

// *** sim/ssr_ctrl_model.sv ***
// remote controller model: answers a service request with one serial poll
// assumes it shares clk and srst with the status logic
`timescale 1ns/1ns
module ssr_ctrl_model (
  input  wire logic clk,             // system clock
  input  wire logic srst,            // power-on clear
  input  wire logic service_request, // request line from device
  output logic      serial_poll      // one-cycle poll pulse
);
  logic polled_q;
  // drive off the sampling edge; poll once per request, re-armed once the line falls
  always @(negedge clk) begin
    serial_poll <= 1'b0;
    if (srst) begin
      polled_q <= 1'b0;
    end else if (service_request && !polled_q) begin
      serial_poll <= 1'b1;
      polled_q    <= 1'b1;
    end else if (!service_request) begin
      polled_q <= 1'b0;
    end
  end
endmodule // ssr_ctrl_model

// *** sim/test_status_service_request.sv ***
// bench for the status byte and event status logic
// assumes the partner model polls on every service request
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_status_service_request;
  import ssr_pkg::*;
  logic clk, srst, opc_cmd, cmds_idle, err_pop, to_local, msg_waiting;
  logic ques_summary, oper_summary, esr_read, stb_read, serial_poll;
  logic service_request, err_empty;
  logic [7:0] ese_q, sre_q, esr_live, esr_rdata, stb_live, stb_rdata;
  logic [15:0] err_head;
  ssr_mask_wr_t mask_wr;
  ssr_err_t err_in;
  int failures, n_checks, cycles;
  logic [7:0] exp;
  ssr_status i_ssr_status (.clk(clk), .srst(srst), .mask_wr(mask_wr),
    .opc_cmd(opc_cmd), .cmds_idle(cmds_idle), .err_in(err_in),
    .err_pop(err_pop), .to_local(to_local), .msg_waiting(msg_waiting),
    .ques_summary(ques_summary), .oper_summary(oper_summary),
    .esr_read(esr_read), .stb_read(stb_read), .serial_poll(serial_poll),
    .event_enable_mask(ese_q), .request_enable_mask(sre_q),
    .standard_event_status(esr_live), .esr_rdata(esr_rdata),
    .summary_status_byte(stb_live), .stb_rdata(stb_rdata),
    .service_request(service_request), .err_head(err_head),
    .err_empty(err_empty));
  ssr_ctrl_model i_ssr_ctrl_model (.clk(clk), .srst(srst),
    .service_request(service_request), .serial_poll(serial_poll));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick();
    @(negedge clk);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // inputs are pulsed for exactly one sampling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask
  task automatic send_err(input ssr_err_kind_t k);
    err_in = '{1'b1, k, 16'hFED4 - 16'(k)};
    tick();
    err_in = '0;
    tick();
  endtask
  // the watchdog allows well over twice the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 300) begin
      failures++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {opc_cmd, err_pop, to_local, msg_waiting, ques_summary} = '0;
    {oper_summary, esr_read, stb_read} = '0;
    cmds_idle = 1'b1;
    mask_wr = '0;
    err_in = '0;
    srst = 1'b1;
    repeat (16) tick();
    srst = 1'b0;
    `CHK(esr_live, 8'h80)
    `CHK(stb_live, 8'h00)
    pulse(esr_read);
    `CHK(esr_rdata, 8'h80)
    `CHK(esr_live, 8'h00)
    mask_wr = '{1'b1, 1'b1, 8'hFF};
    tick();
    mask_wr = '0;
    tick();
    `CHK(ese_q, 8'hFF)
    `CHK(sre_q, 8'hBF)
    // query, device, execution and command errors, one at a time
    for (int k = 1; k <= 4; k++) begin
      exp = 8'h02 << k;
      send_err(ssr_err_kind_t'(k));
      `CHK(esr_live, exp)
      `CHK(stb_live, 8'h64)
      `CHK(service_request, 1'b1)
      pulse(esr_read);
      `CHK(esr_rdata, exp)
    end
    `CHK(stb_rdata[6], 1'b1)
    for (int j = 1; j <= 4; j++) begin
      `CHK(err_head, 16'hFED4 - 16'(j))
      pulse(err_pop);
    end
    `CHK(err_empty, 1'b1)
    `CHK(stb_live, 8'h00)
    tick();
    `CHK(service_request, 1'b0)
    {msg_waiting, ques_summary, oper_summary} = 3'b111;
    tick();
    `CHK(stb_live, 8'hD8)
    {msg_waiting, ques_summary, oper_summary} = 3'b000;
    tick();
    cmds_idle = 1'b0;
    pulse(opc_cmd);
    repeat (3) tick();
    `CHK(esr_live, 8'h00)
    cmds_idle = 1'b1;
    repeat (2) tick();
    `CHK(esr_live, 8'h01)
    pulse(to_local);
    `CHK(esr_live, 8'h41)
    `CHK(stb_live, 8'h60)
    pulse(stb_read);
    `CHK(stb_rdata, 8'h60)
    // one entry beyond the queue depth is dropped, its event bit still set
    repeat (17) send_err(SSR_EV_CMD);
    `CHK(esr_live[5], 1'b1)
    `CHK(err_empty, 1'b0)
    repeat (15) pulse(err_pop);
    `CHK(err_empty, 1'b0)
    pulse(err_pop);
    `CHK(err_empty, 1'b1)
    finish_test();
  end
endmodule // test_status_service_request
